// file: core/itr_pkg.sv
package itr_pkg;

    // target address, upper six bits; lowest bit comes from the select pin
    localparam logic [5:0] ADDR_HI = 6'h34;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;

    localparam int REG_DEPTH = 32;

    // controller clock and bus rate
    localparam int CLK_HZ = 40_000_000;
    localparam int SCL_HZ = 100_000;
    localparam int SCL_QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);

    // device link sampling clock and stuck-low timeout (least time, round up)
    localparam int LINK_PERIOD_PS = 12_000;
    localparam int TIMEOUT_MS = 35;
    localparam longint TIMEOUT_CYC_L = (longint'(TIMEOUT_MS) * 64'd1_000_000_000 + LINK_PERIOD_PS - 1)
        / LINK_PERIOD_PS;
    localparam int TIMEOUT_CYC = int'(TIMEOUT_CYC_L);

    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_READ = 2'h2,
        CMD_STOP = 2'h3
    } itr_cmd_e;

endpackage

// file: core/itr_if.sv
`timescale 1ns/1ps
interface itr_if;
    logic ctl_scl_o;
    logic ctl_scl_oe;
    logic ctl_sda_o;
    logic ctl_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // open-drain wires with pull-up
    assign scl = !(ctl_scl_oe && !ctl_scl_o);
    assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport ctl (input scl, input sda, output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// file: core/itr_ctl.sv
`timescale 1ns/1ps
module itr_ctl #(
    parameter int QUARTER = itr_pkg::SCL_QUARTER_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    itr_if.ctl bus,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire itr_pkg::itr_cmd_e cmd_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_last_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_nack_o
);
    import itr_pkg::*;

    localparam int QW = $clog2(QUARTER + 1);

    typedef enum logic [3:0] {
        C_IDLE = 4'h1,
        C_START = 4'h2,
        C_BYTE = 4'h4,
        C_STOP = 4'h8
    } itr_cst_e;

    typedef struct packed {
        itr_cst_e st;
        logic [QW-1:0] div;
        logic [1:0] q;
        logic [3:0] bits;
        logic [7:0] sh;
        logic rd;
        logic last;
        logic smp;
        logic [1:0] sda_sy;
        logic scl_oe;
        logic sda_oe;
        logic rdy;
        logic rsp_v;
        logic [7:0] rsp_data;
        logic rsp_nack;
    } itr_ctl_s;

    itr_ctl_s r_q;
    itr_ctl_s r_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic bitv;
        logic scl_hi;
        logic sda_hi;
        bitv = 1'h1;
        scl_hi = 1'h1;
        sda_hi = 1'h1;
        r_d = r_q;
        r_d.sda_sy = {r_q.sda_sy[0], bus.sda};
        r_d.rsp_v = 1'h0;
        if (r_q.st == C_IDLE) begin
            r_d.rdy = 1'h1;
            if (cmd_valid_i && r_q.rdy) begin
                r_d.rdy = 1'h0;
                r_d.div = '0;
                r_d.q = 2'h0;
                r_d.bits = 4'h0;
                r_d.sh = cmd_data_i;
                r_d.rd = (cmd_i == CMD_READ);
                r_d.last = cmd_last_i;
                case (cmd_i)
                    CMD_START: r_d.st = C_START;
                    CMD_STOP: r_d.st = C_STOP;
                    default: r_d.st = C_BYTE;
                endcase
            end
        end else if (r_q.div == QW'(QUARTER - 1)) begin
            r_d.div = '0;
            r_d.q = r_q.q + 2'h1;
            if (r_q.q == 2'h2) begin
                r_d.smp = r_q.sda_sy[1];
            end
            if (r_q.q == 2'h3) begin
                if (r_q.st == C_BYTE && r_q.bits != 4'h8) begin
                    // R8: msb first, sampled bit enters at the bottom
                    r_d.sh = {r_q.sh[6:0], r_q.smp};
                    r_d.bits = r_q.bits + 4'h1;
                end else begin
                    r_d.st = C_IDLE;
                    r_d.rsp_v = 1'h1;
                    r_d.rsp_data = r_q.sh;
                    r_d.rsp_nack = r_q.smp;
                end
            end
        end else begin
            r_d.div = r_q.div + QW'(1);
        end

        // pin levels for the quarter now entered
        if (r_d.st == C_BYTE) begin
            if (r_d.bits == 4'h8) begin
                // R11: ack each read byte but the last, which gets a nack
                bitv = r_d.rd ? r_d.last : 1'h1;
            end else begin
                // R3 R4: write shifts data out, read leaves the line free
                bitv = r_d.rd ? 1'h1 : r_d.sh[7];
            end
        end
        // R14: only this end makes clock pulses, start and stop
        case (r_d.st)
            C_START: begin
                scl_hi = (r_d.q == 2'h1) || (r_d.q == 2'h2);
                sda_hi = (r_d.q <= 2'h1);
            end
            C_STOP: begin
                scl_hi = (r_d.q != 2'h0);
                sda_hi = (r_d.q >= 2'h2);
            end
            C_BYTE: begin
                scl_hi = (r_d.q == 2'h1) || (r_d.q == 2'h2);
                sda_hi = bitv;
            end
            default: begin
                scl_hi = !r_q.scl_oe;
                sda_hi = !r_q.sda_oe;
            end
        endcase
        r_d.scl_oe = !scl_hi;
        r_d.sda_oe = !sda_hi;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '{st: C_IDLE, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.ctl_scl_o = 1'h0;
    assign bus.ctl_sda_o = 1'h0;
    assign bus.ctl_scl_oe = r_q.scl_oe;
    assign bus.ctl_sda_oe = r_q.sda_oe;
    assign cmd_ready_o = r_q.rdy;
    assign rsp_valid_o = r_q.rsp_v;
    assign rsp_data_o = r_q.rsp_data;
    assign rsp_nack_o = r_q.rsp_nack;

endmodule

// file: core/itr_dev.sv
// Summary of operation
// R1: answer address 110100 plus select pin
// R2: compare low address bit with pin
// R3: direction 0 means controller writes bytes
// R4: direction 1 means device sends bytes
// R5: first byte after start is address; ack
// R6: first written byte loads register pointer
// R7: accept and acknowledge each following data byte; the code nacks a data byte when its two-entry buffer is full
// R8: all bytes travel most significant bit first
// R9: read starts at current register pointer
// R10: without pointer write, keep last pointer
// R11: controller nacks last read byte
// R12: stop or repeated start ends transfer
// R13: detect start and stop in both roles
// R14: controller alone drives the clock
// R15: controller ends writes with stop
// R16: clock low 35 ms resets interface
// R17: ack held low through ninth pulse
// R18: pointer advances after each data byte
// R19: mismatched address: release, ignore until start
`timescale 1ns/1ps
module itr_dev #(
    parameter int DEPTH = itr_pkg::REG_DEPTH,
    parameter int TIMEOUT_CYC = itr_pkg::TIMEOUT_CYC
) (
    input wire logic link_clk_i,
    input wire logic clk_i,
    input wire logic rst_i,
    itr_if.dev bus,
    input wire logic address_select_pin_i,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic busy_o
);
    import itr_pkg::*;

    localparam int IW = $clog2(DEPTH);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    typedef enum logic [4:0] {
        L_IDLE = 5'h01,
        L_RX = 5'h02,
        L_RACK = 5'h04,
        L_TX = 5'h08,
        L_TACK = 5'h10
    } itr_lst_e;

    typedef struct packed {
        itr_lst_e st;
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] sel_sy;
        logic scl_p;
        logic sda_p;
        logic [3:0] bits;
        logic [7:0] sh;
        logic is_addr;
        logic is_ptr;
        logic rd;
        logic [7:0] ptr;
        logic [DEPTH-1:0][7:0] mem;
        logic drive;
        logic [TW-1:0] tmo;
        logic [1:0][15:0] fifo;
        logic [1:0] cnt;
        logic wp;
        logic rp;
        logic [15:0] xw;
        logic req;
        logic [1:0] ack_sy;
        logic act;
    } itr_lnk_s;

    typedef struct packed {
        logic [1:0] req_sy;
        logic seen;
        logic ack;
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
        logic busy_m;
        logic busy;
    } itr_usr_s;

    itr_lnk_s l_q;
    itr_lnk_s l_d;
    itr_usr_s u_q;
    itr_usr_s u_d;

    ////////////////////////////////////////////////////////////////////////
    // link domain: bus pins oversampled by the link clock
    always_comb begin
        logic scl_h;
        logic sda_h;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic push;
        logic pop;
        logic [7:0] b;
        scl_h = l_q.scl_sy[1];
        sda_h = l_q.sda_sy[1];
        rise = scl_h && !l_q.scl_p;
        fall = !scl_h && l_q.scl_p;
        start = scl_h && l_q.scl_p && l_q.sda_p && !sda_h;
        stop = scl_h && l_q.scl_p && !l_q.sda_p && sda_h;
        push = 1'h0;
        pop = 1'h0;
        b = l_q.sh;
        l_d = l_q;
        l_d.scl_sy = {l_q.scl_sy[0], bus.scl};
        l_d.sda_sy = {l_q.sda_sy[0], bus.sda};
        l_d.sel_sy = {l_q.sel_sy[0], address_select_pin_i};
        l_d.ack_sy = {l_q.ack_sy[0], u_q.ack};
        l_d.scl_p = scl_h;
        l_d.sda_p = sda_h;

        if (scl_h) begin
            l_d.tmo = '0;
        end else if (l_q.tmo != TW'(TIMEOUT_CYC)) begin
            l_d.tmo = l_q.tmo + TW'(1);
        end

        case (l_q.st)
            L_RX: begin
                if (rise && l_q.bits != 4'h8) begin
                    // R8: msb arrives first
                    l_d.sh = {l_q.sh[6:0], sda_h};
                    l_d.bits = l_q.bits + 4'h1;
                end else if (fall && l_q.bits == 4'h8) begin
                    l_d.st = L_RACK;
                    l_d.drive = 1'h1;
                    if (l_q.is_addr) begin
                        // R1 R2: fixed upper bits, low bit against the pin now
                        if (b[7:2] == ADDR_HI && b[1] == l_q.sel_sy[1]) begin
                            // R5: claim with an ack; R3 R4: direction bit
                            l_d.is_addr = 1'h0;
                            l_d.rd = (b[0] == DIR_READ);
                            l_d.is_ptr = (b[0] == DIR_WRITE);
                        end else begin
                            // R19: stay off the line until the next start
                            l_d.st = L_IDLE;
                            l_d.drive = 1'h0;
                        end
                    end else if (l_q.is_ptr) begin
                        // R6: pointer byte
                        l_d.ptr = b;
                        l_d.is_ptr = 1'h0;
                    end else if (l_q.cnt != 2'h2) begin
                        // R7: store, ack; R18: next register
                        l_d.mem[l_q.ptr[IW-1:0]] = b;
                        l_d.ptr = l_q.ptr + 8'h1;
                        push = 1'h1;
                    end else begin
                        // no clock stretching allowed, so a full buffer nacks
                        l_d.st = L_IDLE;
                        l_d.drive = 1'h0;
                    end
                end
            end
            L_RACK: begin
                // R17: ack stays low until the ninth pulse falls
                if (fall) begin
                    l_d.bits = 4'h0;
                    l_d.drive = 1'h0;
                    l_d.st = L_RX;
                    if (l_q.rd) begin
                        // R9 R10: read from wherever the pointer stands
                        l_d.sh = l_q.mem[l_q.ptr[IW-1:0]];
                        // R18: pointer advances per sent byte
                        l_d.ptr = l_q.ptr + 8'h1;
                        l_d.drive = !l_d.sh[7];
                        l_d.st = L_TX;
                    end
                end
            end
            L_TX: begin
                if (rise) begin
                    l_d.bits = l_q.bits + 4'h1;
                end else if (fall && l_q.bits == 4'h8) begin
                    l_d.drive = 1'h0;
                    l_d.st = L_TACK;
                end else if (fall) begin
                    // R8: next lower bit
                    l_d.sh = {l_q.sh[6:0], 1'h0};
                    l_d.drive = !l_d.sh[7];
                end
            end
            L_TACK: begin
                if (rise && sda_h) begin
                    // R11: nack from the controller ends the read
                    l_d.st = L_IDLE;
                end else if (rise) begin
                    l_d.bits = 4'h9;
                end else if (fall && l_q.bits == 4'h9) begin
                    l_d.bits = 4'h0;
                    l_d.sh = l_q.mem[l_q.ptr[IW-1:0]];
                    l_d.ptr = l_q.ptr + 8'h1;
                    l_d.drive = !l_d.sh[7];
                    l_d.st = L_TX;
                end
            end
            default: begin
                l_d.drive = 1'h0;
            end
        endcase

        // R13 R12: start or repeated start re-arms address decode, stop ends it
        if (start) begin
            l_d.st = L_RX;
            l_d.bits = 4'h0;
            l_d.is_addr = 1'h1;
            l_d.is_ptr = 1'h0;
            l_d.drive = 1'h0;
        end else if (stop) begin
            l_d.st = L_IDLE;
            l_d.drive = 1'h0;
        end
        // R16: stuck clock drops the transfer and frees the data line
        if (l_q.tmo == TW'(TIMEOUT_CYC)) begin
            l_d.st = L_IDLE;
            l_d.drive = 1'h0;
        end
        // registered single bit, so the user side never samples a half-changed state code
        l_d.act = (l_d.st != L_IDLE);

        // two-entry buffer drained by a toggle handshake
        if (l_q.cnt != 2'h0 && l_q.req == l_q.ack_sy[1]) begin
            pop = 1'h1;
            l_d.xw = l_q.fifo[l_q.rp];
            l_d.req = !l_q.req;
            l_d.rp = !l_q.rp;
        end
        if (push) begin
            l_d.fifo[l_q.wp] = {l_q.ptr, b};
            l_d.wp = !l_q.wp;
        end
        l_d.cnt = l_q.cnt + {1'h0, push} - {1'h0, pop};
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l_q <= '{st: L_IDLE, scl_sy: 2'h3, sda_sy: 2'h3, scl_p: 1'h1, sda_p: 1'h1, default: '0};
        end else begin
            l_q <= l_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user domain: one written register at a time
    always_comb begin
        u_d = u_q;
        u_d.req_sy = {u_q.req_sy[0], l_q.req};
        u_d.busy_m = l_q.act;
        u_d.busy = u_q.busy_m;
        if (u_q.valid && wr_ready_i) begin
            u_d.valid = 1'h0;
            u_d.ack = u_q.seen;
        end else if (!u_q.valid && u_q.req_sy[1] != u_q.seen) begin
            // word was loaded in the same link cycle the request toggled, and held until the ack
            u_d.seen = u_q.req_sy[1];
            u_d.valid = 1'h1;
            u_d.addr = l_q.xw[15:8];
            u_d.data = l_q.xw[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            u_q <= '0;
        end else begin
            u_q <= u_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.dev_sda_o = 1'h0;
    assign bus.dev_sda_oe = l_q.drive;
    assign wr_valid_o = u_q.valid;
    assign wr_addr_o = u_q.addr;
    assign wr_data_o = u_q.data;
    assign busy_o = u_q.busy;

endmodule

// file: test/itr_asserts.sv
`timescale 1ns/1ps
module itr_asserts import itr_pkg::*; #(
    parameter int TIMEOUT_CYC = 200
) (
    input wire logic link_clk_i,
    input wire logic rst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic address_select_pin_i
);
    import itr_pkg::*;

    logic scl_p, sda_p, rd_q, ign_q, past_q;
    logic [3:0] n_q;
    logic [7:0] sh_q;
    int tmo_q;
    wire logic start = scl && scl_p && sda_p && !sda;
    wire logic rise = scl && !scl_p;

    ////////////////////////////////////////////////////////////////////////
    // bus tracker; raw lines are sampled, so limits leave room for sync lag
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_p <= 1'h1;
            sda_p <= 1'h1;
            rd_q <= 1'h0;
            ign_q <= 1'h0;
            past_q <= 1'h0;
            n_q <= 4'h0;
            sh_q <= 8'h00;
            tmo_q <= 0;
        end else begin
            scl_p <= scl;
            sda_p <= sda;
            tmo_q <= scl ? 0 : (tmo_q < TIMEOUT_CYC + 16 ? tmo_q + 1 : tmo_q);
            if (start) begin
                n_q <= 4'h0;
                past_q <= 1'h0;
                rd_q <= 1'h0;
                ign_q <= 1'h0;
            end else if (rise) begin
                sh_q <= {sh_q[6:0], sda};
                n_q <= (n_q == 4'h8) ? 4'h0 : n_q + 4'h1;
                if (n_q == 4'h8) past_q <= 1'h1;
                if (n_q == 4'h7 && !past_q) begin
                    rd_q <= sda;
                    ign_q <= sh_q[6:0] != {ADDR_HI, address_select_pin_i};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge link_clk_i); endclocking
    default disable iff (rst_i);

    property p_addr_ack;
        rise && n_q == 4'h8 && !past_q && !ign_q |-> dev_sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acknowledged");
    property p_addr_nack;
        ign_q |-> !dev_sda_oe;
    endproperty
    a_addr_nack: assert property (p_addr_nack)
        else $error("data line driven after address mismatch");
    property p_hold_high;
        scl && scl_p |-> $stable(dev_sda_oe);
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("device changed data line while clock high");
    property p_cond;
        scl && scl_p && sda != sda_p |-> !dev_sda_oe && !$past(dev_sda_oe);
    endproperty
    a_cond: assert property (p_cond)
        else $error("device took part in start or stop");
    property p_rd_rel;
        rise && n_q == 4'h8 && past_q && rd_q |-> !dev_sda_oe;
    endproperty
    a_rd_rel: assert property (p_rd_rel)
        else $error("device drove the controller acknowledge slot");
    property p_wr_quiet;
        rise && n_q != 4'h8 && !rd_q |-> !dev_sda_oe;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet)
        else $error("device drove a bit of a received byte");
    property p_ack_end;
        !scl && scl_p && n_q == 4'h0 && past_q && !rd_q |-> ##[1:8] !dev_sda_oe;
    endproperty
    a_ack_end: assert property (p_ack_end)
        else $error("acknowledge not released after ninth pulse");
    property p_tmo;
        tmo_q >= TIMEOUT_CYC + 8 |-> !dev_sda_oe;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("data line held after clock low timeout");
endmodule

// file: test/i2c_target_register_access_bench.sv
`timescale 1ns/1ps
module i2c_target_register_access_bench;
    import itr_pkg::*;

    localparam int TMO = 200;
    localparam logic [7:0] AW = {ADDR_HI, 1'h0, DIR_WRITE};
    localparam logic [7:0] AR = {ADDR_HI, 1'h0, DIR_READ};
    logic clk_i, link_clk_i, rst_i, cmd_valid, cmd_last, pin, wr_ready;
    itr_cmd_e cmd;
    logic [7:0] cmd_data;
    logic cmd_ready, rsp_valid, rsp_nack, wr_valid, busy;
    logic [7:0] rsp_data, wr_addr, wr_data;
    logic [15:0] got[$];
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    itr_if itr_if_inst ();
    itr_ctl #(.QUARTER(8)) itr_ctl_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(itr_if_inst.ctl),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_i(cmd), .cmd_data_i(cmd_data),
        .cmd_last_i(cmd_last), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
    itr_dev #(.TIMEOUT_CYC(TMO)) itr_dev_inst (.link_clk_i(link_clk_i), .clk_i(clk_i), .rst_i(rst_i),
        .bus(itr_if_inst.dev), .address_select_pin_i(pin), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .busy_o(busy));
    itr_asserts #(.TIMEOUT_CYC(TMO)) itr_asserts_inst (.link_clk_i(link_clk_i), .rst_i(rst_i),
        .scl(itr_if_inst.scl), .sda(itr_if_inst.sda), .dev_sda_oe(itr_if_inst.dev_sda_oe),
        .address_select_pin_i(pin));

    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end
    // link sampling clock, offset so the domains never line up
    initial begin
        link_clk_i = 1'h0;
        #3.3;
        forever #6 link_clk_i = ~link_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (wr_valid && wr_ready) got.push_back({wr_addr, wr_data});
        if (cycles == 25000) begin
            err_total++;
            wrap_up();
        end
    end

    // request held until taken, answer read at the rsp_valid edge
    task automatic op(input itr_cmd_e c, input logic [7:0] d = 8'h00, input logic l = 1'h0);
        cmd <= c;
        cmd_data <= d;
        cmd_last <= l;
        cmd_valid <= 1'h1;
        @(posedge clk_i);
        while (cmd_ready !== 1'h1) @(posedge clk_i);
        cmd_valid <= 1'h0;
        do @(posedge clk_i); while (rsp_valid !== 1'h1);
    endtask

    task wb(input logic [7:0] d, input logic nk);
        op(CMD_WRITE, d);
        chk({15'h0, rsp_nack}, {15'h0, nk});
    endtask

    task rb(input logic [7:0] e, input logic l);
        op(CMD_READ, 8'h00, l);
        chk({8'h0, rsp_data}, {8'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'h1;
        cmd_valid = 1'h0;
        cmd = CMD_START;
        cmd_data = 8'h00;
        cmd_last = 1'h0;
        pin = 1'h0;
        wr_ready = 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        op(CMD_START);
        chk({15'h0, busy}, 16'h1);
        wb(AW, 1'h0);
        wb(8'h05, 1'h0);
        wb(8'ha5, 1'h0);
        wb(8'h3c, 1'h0);
        wb(8'h5a, 1'h0);
        op(CMD_STOP);
        chk({15'h0, busy}, 16'h0);
        chk(16'(got.size()), 16'h3);
        chk(got[0], 16'h05a5);
        chk(got[1], 16'h063c);
        chk(got[2], 16'h075a);
        got.delete();
        // pointer set, then repeated start into a read
        op(CMD_START);
        wb(AW, 1'h0);
        wb(8'h05, 1'h0);
        op(CMD_START);
        wb(AR, 1'h0);
        rb(8'ha5, 1'h0);
        rb(8'h3c, 1'h1);
        op(CMD_STOP);
        // read with no pointer write resumes where the last one left off
        op(CMD_START);
        wb(AR, 1'h0);
        rb(8'h5a, 1'h1);
        op(CMD_STOP);
        for (int i = 0; i < 4; i++) begin
            pin <= i[1];
            op(CMD_START);
            wb({ADDR_HI, i[0], DIR_WRITE}, i[0] ^ i[1]);
            op(CMD_STOP);
        end
        pin <= 1'h0;
        // stalled stream: one word held at the output, two buffered, fourth refused
        wr_ready <= 1'h0;
        op(CMD_START);
        wb(AW, 1'h0);
        wb(8'h10, 1'h0);
        wb(8'hc1, 1'h0);
        wb(8'hc2, 1'h0);
        wb(8'hc3, 1'h0);
        wb(8'hc4, 1'h1);
        op(CMD_STOP);
        wr_ready <= 1'h1;
        for (int k = 0; k < 100 && got.size() < 3; k++) @(posedge clk_i);
        chk(16'(got.size()), 16'h3);
        chk(got[0], 16'h10c1);
        chk(got[1], 16'h11c2);
        chk(got[2], 16'h12c3);
        // clock parked low while the device drives a zero bit
        op(CMD_START);
        wb(AW, 1'h0);
        wb(8'h00, 1'h0);
        op(CMD_START);
        wb(AR, 1'h0);
        rb(8'h00, 1'h0);
        // the controller itself still pulls the data line for its ack, so watch the device's enable
        repeat (20) @(posedge clk_i);
        chk({15'h0, itr_if_inst.dev_sda_oe}, 16'h1);
        repeat (130) @(posedge clk_i);
        chk({15'h0, itr_if_inst.dev_sda_oe}, 16'h0);
        chk({15'h0, busy}, 16'h0);
        op(CMD_STOP);
        wrap_up();
    end
endmodule
